// ---- hw/sensor_frame_timing.sv ----
// module: row and frame timing sequencer with slave trigger and output sync markers
// What this block does
// - row period equals clocks-per-row count
// - rows per frame counts active plus blanking
// - blanking: dark, embedded, blank, at least four idle
// - dark select 8, 4 or 2 rows
// - embedded enable picks embedded or blank rows
// - free run restarts after extra delay
// - sync edge starts frame; hold-off frame plus 16
// - edges during hold-off are dropped
// - waiting halts read and reset pointers
// - waiting lengthens only rows already reset
// - blanking rows first, active rows last
// - frame is rows times row period
// - parallel output marks frame and line valid
// - serial codes chosen by protocol
// - extra delay clocks appended to each frame
// - stream clear stops after current frame
`timescale 1ns/1ps
`default_nettype none
module sensor_frame_timing (
  // clock, reset and enable
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [15:0]      regRdata,
  // frame sync pin
  input  wire logic        frameSyncPulse,
  // parallel markers
  output logic             frameValidOut,
  output logic             lineValidOut,
  // serial sync code requests
  output logic             blankRowStartCode,
  output logic             frameStartCode,
  output logic             lineStartCode,
  output logic             lineEndCode,
  output logic             frameEndCode,
  // row pointers and row kind
  output logic [15:0]      rowReadPtr,
  output logic [15:0]      rowResetPtr,
  output logic             pointerRun,
  output sft_pkg::sft_row_t rowKindOut
);
  import sft_pkg::*;

  // settings latched at frame start
  typedef struct packed {
    logic [15:0] lineLen;
    logic [15:0] frameRows;
    logic [15:0] vblank;
    logic [15:0] extra;
    logic [15:0] actCols;
    logic [15:0] dark;
    logic [15:0] integ;
    logic        embEn;
    sft_proto_t  proto;
  } sft_cfg_t;

  // all state of the sequencer
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] lineLen;
    logic [15:0] frmLen;
    logic [15:0] extra;
    logic [15:0] actRows;
    logic [15:0] actCols;
    logic [15:0] integ;
    logic [15:0] rdata;
    sft_cfg_t    cfg;
    sft_state_t  state;
    logic [15:0] col;
    logic [15:0] row;
    logic [15:0] extraCnt;
    logic [4:0]  guardCnt;
    logic [15:0] frmCnt;
    logic [15:0] readPtr;
    logic [15:0] rstPtr;
    logic        fv;
    logic        lv;
    logic        codeBlank;
    logic        codeFs;
    logic        codeLs;
    logic        codeLe;
    logic        codeFe;
    sft_row_t    kind;
  } sft_st_t;

  sft_st_t stQ;  // registered state
  sft_st_t stD;  // next state

  sft_trig_if trig ();  // synchronised trigger

  // trigger synchroniser
  sft_trig_sync uTrig (
    .clk_sys        (clk_sys),
    .rst            (rst),
    .clkEn          (clkEn),
    .frameSyncPulse (frameSyncPulse),
    .trig           (trig)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode functions

  // dark row count from the selection field; unknown codes give eight
  function automatic logic [15:0] darkRows(input logic [3:0] sel);
    case (sel)
      SFT_DARK_SEL4: darkRows = SFT_DARK_ROWS4;
      SFT_DARK_SEL2: darkRows = SFT_DARK_ROWS2;
      default:       darkRows = SFT_DARK_ROWS8;
    endcase
  endfunction

  // kind of row at an index; blanking rows lead, active rows trail
  function automatic sft_row_t rowKind(input logic [15:0] r, input sft_cfg_t c);
    if (r < c.dark) begin
      rowKind = SFT_ROW_DARK;
    end else if (r < c.dark + SFT_EMB_ROWS) begin
      rowKind = c.embEn ? SFT_ROW_EMBED : SFT_ROW_BLANK;
    end else if (r < c.dark + SFT_EMB_ROWS + SFT_BLANK_ROWS) begin
      rowKind = SFT_ROW_BLANK;
    end else if (r < c.vblank) begin
      rowKind = SFT_ROW_IDLE;
    end else begin
      rowKind = SFT_ROW_ACTIVE;
    end
  endfunction

  // code index: 0 blank row, 1 frame start, 2 line start, 3 line end, 4 frame end
  function automatic logic protoHas(input sft_proto_t p, input logic [2:0] code);
    case (p)
      SFT_PROTO_STREAM_S:  protoHas = (code == 3'h0) || (code == 3'h2);
      SFT_PROTO_STREAM_SP: protoHas = (code <= 3'h2);
      SFT_PROTO_PACKET_SP: protoHas = (code != 3'h0);
      default:             protoHas = 1'b0;
    endcase
  endfunction

  // snapshot of the software settings for the next frame
  function automatic sft_cfg_t takeCfg(input sft_st_t s);
    logic [15:0] minRows;
    minRows = s.actRows + darkRows(s.ctrl[SFT_CTRL_DARK +: 4]) + SFT_EMB_ROWS
              + SFT_BLANK_ROWS + SFT_MIN_IDLE_ROWS;
    takeCfg.lineLen   = s.lineLen;
    takeCfg.frameRows = (s.frmLen < minRows) ? minRows : s.frmLen;
    takeCfg.vblank    = takeCfg.frameRows - s.actRows;
    takeCfg.extra     = s.extra;
    takeCfg.actCols   = s.actCols;
    takeCfg.dark      = darkRows(s.ctrl[SFT_CTRL_DARK +: 4]);
    takeCfg.integ     = s.integ;
    takeCfg.embEn     = s.ctrl[SFT_CTRL_EMB_EN];
    takeCfg.proto     = sft_proto_t'(s.ctrl[SFT_CTRL_PROTO +: 2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic     lastCol;   // final clock of a row
    logic     lastRow;   // final row of a frame
    logic     slaveOn;   // slave mode selected
    logic     startNew;  // a frame begins next cycle
    logic     frameEnd;  // frame period incl. extra delay is over
    sft_row_t kindNow;   // kind of the current row
    stD      = stQ;
    lastCol  = 1'b0;
    lastRow  = 1'b0;
    startNew = 1'b0;
    frameEnd = 1'b0;
    slaveOn  = stQ.ctrl[SFT_CTRL_SLAVE];
    kindNow  = rowKind(stQ.row, stQ.cfg);
    if (clkEn) begin
      // register writes and reads
      stD.rdata = '0;
      if (regWr) begin
        case (regAddr)
          SFT_REG_CTRL:     stD.ctrl    = regWdata;
          SFT_REG_LINE_LEN: stD.lineLen = regWdata;
          SFT_REG_FRM_LEN:  stD.frmLen  = regWdata;
          SFT_REG_EXTRA:    stD.extra   = regWdata;
          SFT_REG_ACT_ROWS: stD.actRows = regWdata;
          SFT_REG_ACT_COLS: stD.actCols = regWdata;
          SFT_REG_INTEG:    stD.integ   = regWdata;
          default:          ;  // read-only or unmapped: ignored
        endcase
      end
      if (regRd) begin
        case (regAddr)
          SFT_REG_CTRL:     stD.rdata = stQ.ctrl;
          SFT_REG_LINE_LEN: stD.rdata = stQ.lineLen;
          SFT_REG_FRM_LEN:  stD.rdata = stQ.frmLen;
          SFT_REG_EXTRA:    stD.rdata = stQ.extra;
          SFT_REG_ACT_ROWS: stD.rdata = stQ.actRows;
          SFT_REG_ACT_COLS: stD.rdata = stQ.actCols;
          SFT_REG_INTEG:    stD.rdata = stQ.integ;
          SFT_REG_STATUS:   stD.rdata = {12'h000, trig.level, stQ.state};
          SFT_REG_READ_PTR: stD.rdata = stQ.readPtr;
          SFT_REG_RST_PTR:  stD.rdata = stQ.rstPtr;
          SFT_REG_FRM_CNT:  stD.rdata = stQ.frmCnt;
          default:          stD.rdata = '0;
        endcase
      end

      // markers default to idle each cycle
      stD.fv        = 1'b0;
      stD.lv        = 1'b0;
      stD.codeBlank = 1'b0;
      stD.codeFs    = 1'b0;
      stD.codeLs    = 1'b0;
      stD.codeLe    = 1'b0;
      stD.codeFe    = 1'b0;

      // sequencer
      case (stQ.state)
        SFT_ST_STANDBY: begin
          // leave standby on the streaming bit
          if (stQ.ctrl[SFT_CTRL_STREAM]) begin
            if (slaveOn) begin
              stD.state = SFT_ST_WAIT;
            end else begin
              startNew = 1'b1;
            end
          end
        end
        SFT_ST_WAIT: begin
          // pointers frozen while waiting for a sync edge
          if (!stQ.ctrl[SFT_CTRL_STREAM]) begin
            stD.state = SFT_ST_STANDBY;
          end else if (!slaveOn) begin
            startNew = 1'b1;
          end else if (stQ.ctrl[SFT_CTRL_TRIG_EN] && trig.riseEdge) begin
            startNew = 1'b1;
          end
        end
        SFT_ST_ROWS: begin
          // column and row counting through the frame
          lastCol = (stQ.col >= stQ.cfg.lineLen - 16'h0001);
          lastRow = (stQ.row >= stQ.cfg.frameRows - 16'h0001);
          stD.col = lastCol ? 16'h0000 : stQ.col + 16'h0001;
          if (lastCol) begin
            if (lastRow) begin
              if (stQ.cfg.extra != 16'h0000) begin
                stD.state    = SFT_ST_EXTRA;
                stD.extraCnt = 16'h0000;
              end else begin
                frameEnd = 1'b1;
              end
            end else begin
              stD.row     = stQ.row + 16'h0001;
              stD.readPtr = stQ.row + 16'h0001;
              stD.rstPtr  = (stQ.rstPtr >= stQ.cfg.frameRows - 16'h0001) ? 16'h0000
                            : stQ.rstPtr + 16'h0001;
            end
          end
          // parallel markers and serial codes for this clock
          stD.kind = kindNow;
          if (kindNow == SFT_ROW_ACTIVE) begin
            stD.fv = 1'b1;
            stD.lv = stQ.col < stQ.cfg.actCols;
            if (stQ.col == 16'h0000) begin
              stD.codeLs = protoHas(stQ.cfg.proto, 3'h2);
            end
            if (stQ.col == stQ.cfg.actCols) begin
              stD.codeLe = protoHas(stQ.cfg.proto, 3'h3);
              stD.codeFe = lastRow && protoHas(stQ.cfg.proto, 3'h4);
            end
          end else if (stQ.col == 16'h0000) begin
            stD.codeBlank = protoHas(stQ.cfg.proto, 3'h0);
          end
        end
        SFT_ST_EXTRA: begin
          // extra clocks appended after the last row
          stD.extraCnt = stQ.extraCnt + 16'h0001;
          if (stQ.extraCnt >= stQ.cfg.extra - 16'h0001) begin
            frameEnd = 1'b1;
          end
        end
        SFT_ST_GUARD: begin
          // slave hold-off; sync edges here are dropped
          stD.guardCnt = stQ.guardCnt + 5'h01;
          if (stQ.guardCnt >= SFT_GUARD_CYCLES - 5'h01) begin
            stD.state = stQ.ctrl[SFT_CTRL_STREAM] ? SFT_ST_WAIT
                        : SFT_ST_STANDBY;
          end
        end
        default: begin
          stD.state = SFT_ST_STANDBY;
        end
      endcase

      // end of a frame period: standby, hold-off or free-running restart
      if (frameEnd) begin
        if (!stQ.ctrl[SFT_CTRL_STREAM]) begin
          stD.state = SFT_ST_STANDBY;
        end else if (slaveOn) begin
          stD.state    = SFT_ST_GUARD;
          stD.guardCnt = '0;
        end else begin
          startNew = 1'b1;
        end
      end

      // frame start: latch settings, clear row and column counters, count the frame, request a frame start code where the protocol has one
      if (startNew) begin
        stD.state    = SFT_ST_ROWS;
        stD.cfg      = takeCfg(stQ);
        stD.col      = '0;
        stD.row      = '0;
        stD.readPtr  = '0;
        stD.rstPtr   = (stQ.integ < stD.cfg.frameRows) ? stD.cfg.frameRows - stQ.integ
                       : 16'h0000;
        stD.frmCnt   = stQ.frmCnt + 16'h0001;
        stD.codeFs   = protoHas(stD.cfg.proto, 3'h1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stQ         <= '0;
      stQ.ctrl    <= SFT_RST_CTRL;
      stQ.lineLen <= SFT_RST_LINE_LEN;
      stQ.frmLen  <= SFT_RST_FRM_LEN;
      stQ.extra   <= SFT_RST_EXTRA;
      stQ.actRows <= SFT_RST_ACT_ROWS;
      stQ.actCols <= SFT_RST_ACT_COLS;
      stQ.integ   <= SFT_RST_INTEG;
      stQ.state   <= SFT_ST_STANDBY;
      stQ.kind    <= SFT_ROW_DARK;
      stQ.cfg.proto <= SFT_PROTO_PARALLEL;
    end else begin
      stQ <= stD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from the state register
  assign regRdata          = stQ.rdata;
  assign frameValidOut     = stQ.fv;
  assign lineValidOut      = stQ.lv;
  assign blankRowStartCode = stQ.codeBlank;
  assign frameStartCode    = stQ.codeFs;
  assign lineStartCode     = stQ.codeLs;
  assign lineEndCode       = stQ.codeLe;
  assign frameEndCode      = stQ.codeFe;
  assign rowReadPtr        = stQ.readPtr;
  assign rowResetPtr       = stQ.rstPtr;
  assign pointerRun        = (stQ.state == SFT_ST_ROWS);
  assign rowKindOut        = stQ.kind;
endmodule
`default_nettype wire

// ---- hw/sft_pkg.sv ----
// package: register map, reset values, field positions and timing constants of the frame timer
package sft_pkg;

  // register indices on the plain register port
  localparam logic [3:0] SFT_REG_CTRL     = 4'h0;
  localparam logic [3:0] SFT_REG_LINE_LEN = 4'h1;
  localparam logic [3:0] SFT_REG_FRM_LEN  = 4'h2;
  localparam logic [3:0] SFT_REG_EXTRA    = 4'h3;
  localparam logic [3:0] SFT_REG_ACT_ROWS = 4'h4;
  localparam logic [3:0] SFT_REG_ACT_COLS = 4'h5;
  localparam logic [3:0] SFT_REG_INTEG    = 4'h6;
  localparam logic [3:0] SFT_REG_STATUS   = 4'h7;
  localparam logic [3:0] SFT_REG_READ_PTR = 4'h8;
  localparam logic [3:0] SFT_REG_RST_PTR  = 4'h9;
  localparam logic [3:0] SFT_REG_FRM_CNT  = 4'ha;

  // control register field positions
  localparam int SFT_CTRL_STREAM  = 0;
  localparam int SFT_CTRL_SLAVE   = 1;
  localparam int SFT_CTRL_TRIG_EN = 2;
  localparam int SFT_CTRL_EMB_EN  = 3;
  localparam int SFT_CTRL_PROTO   = 4;
  localparam int SFT_CTRL_DARK    = 8;

  // reset values
  localparam logic [15:0] SFT_RST_CTRL     = 16'h0808;
  localparam logic [15:0] SFT_RST_LINE_LEN = 16'h044c;
  localparam logic [15:0] SFT_RST_FRM_LEN  = 16'h0448;
  localparam logic [15:0] SFT_RST_EXTRA    = 16'h0000;
  localparam logic [15:0] SFT_RST_ACT_ROWS = 16'h0438;
  localparam logic [15:0] SFT_RST_ACT_COLS = 16'h03c0;
  localparam logic [15:0] SFT_RST_INTEG    = 16'h0010;

  // dark row selection codes and their row counts
  localparam logic [3:0]  SFT_DARK_SEL8 = 4'h8;
  localparam logic [3:0]  SFT_DARK_SEL4 = 4'h4;
  localparam logic [3:0]  SFT_DARK_SEL2 = 4'h2;
  localparam logic [15:0] SFT_DARK_ROWS8 = 16'h0008;
  localparam logic [15:0] SFT_DARK_ROWS4 = 16'h0004;
  localparam logic [15:0] SFT_DARK_ROWS2 = 16'h0002;

  // fixed blanking rows: two embedded (or blank), two blank, minimum four idle
  localparam logic [15:0] SFT_EMB_ROWS      = 16'h0002;
  localparam logic [15:0] SFT_BLANK_ROWS    = 16'h0002;
  localparam logic [15:0] SFT_MIN_IDLE_ROWS = 16'h0004;

  // slave hold-off beyond one frame period
  localparam int          SFT_GUARD_NS     = 160;
  localparam int          SFT_CLK_PERIOD_NS = 10;
  localparam logic [4:0]  SFT_GUARD_CYCLES = 5'((SFT_GUARD_NS + SFT_CLK_PERIOD_NS - 1)
                                                / SFT_CLK_PERIOD_NS);

  // serial protocols
  typedef enum logic [1:0] {
    SFT_PROTO_PARALLEL,
    SFT_PROTO_STREAM_S,
    SFT_PROTO_STREAM_SP,
    SFT_PROTO_PACKET_SP
  } sft_proto_t;

  // kinds of rows inside a frame
  typedef enum logic [2:0] {
    SFT_ROW_DARK,
    SFT_ROW_EMBED,
    SFT_ROW_BLANK,
    SFT_ROW_IDLE,
    SFT_ROW_ACTIVE
  } sft_row_t;

  // sequencer states
  typedef enum logic [2:0] {
    SFT_ST_STANDBY,
    SFT_ST_WAIT,
    SFT_ST_ROWS,
    SFT_ST_EXTRA,
    SFT_ST_GUARD
  } sft_state_t;

endpackage

// ---- hw/sft_trig_if.sv ----
// interface: synchronised trigger edge handed from the trigger stage to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface sft_trig_if;
  logic riseEdge;  // one-cycle pulse on a rising trigger edge
  logic level;     // synchronised trigger level
  modport src (output riseEdge, output level);
  modport dst (input riseEdge, input level);
endinterface
`default_nettype wire

// ---- hw/sft_trig_sync.sv ----
// module: two-flop synchroniser and rising edge detector for the frame sync pin
`timescale 1ns/1ps
`default_nettype none
module sft_trig_sync (
  // clock, reset and enable
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic clkEn,
  // frame sync pin
  input  wire logic frameSyncPulse,
  // synchronised result
  sft_trig_if.src   trig
);
  import sft_pkg::*;

  // all state: two sync stages and the previous synchronised level
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sft_sync_st_t;

  sft_sync_st_t syncQ;  // registered state
  sft_sync_st_t syncD;  // next state

  ////////////////////////////////////////////////////////////////////////////
  // next state: first stage feeds only the second
  always_comb begin
    syncD = syncQ;
    if (clkEn) begin
      syncD.meta = frameSyncPulse;
      syncD.sync = syncQ.meta;
      syncD.prev = syncQ.sync;
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      syncQ <= '0;
    end else begin
      syncQ <= syncD;
    end
  end

  // edge seen only from the second stage onward
  assign trig.riseEdge = clkEn & syncQ.sync & ~syncQ.prev;
  assign trig.level    = syncQ.sync;
endmodule
`default_nettype wire

// ---- tb/sft_sync_source.sv ----
// partner: external controller driving frame sync pulses on the trigger pin
`timescale 1ns/1ps
`default_nettype none
module sft_sync_source (
  // clock
  input  wire logic clk_sys,
  // trigger pin, low between pulses
  output var  logic frameSyncPulse
);
  initial frameSyncPulse = 1'b0;
  ////////////////////////////////////////////////////////////
  // one pulse, raised after an edge and held at least three clocks
  task automatic send(input int w);
    @(posedge clk_sys);
    frameSyncPulse <= 1'b1;
    repeat ((w < 3) ? 3 : w) @(posedge clk_sys);
    frameSyncPulse <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/sft_monitor.sv ----
// checker: port-level properties of the frame timer
`timescale 1ns/1ps
`default_nettype none
module sft_monitor (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              rst,
  // register port
  input wire logic [3:0]        regAddr,
  input wire logic              regRd,
  input wire logic [15:0]       regRdata,
  // markers and pointers
  input wire logic              frameValidOut,
  input wire logic              lineValidOut,
  input wire logic              blankRowStartCode,
  input wire logic              lineStartCode,
  input wire logic              lineEndCode,
  input wire logic              frameEndCode,
  input wire logic [15:0]       rowReadPtr,
  input wire logic [15:0]       rowResetPtr,
  input wire logic              pointerRun,
  input wire sft_pkg::sft_row_t rowKindOut
);
  import sft_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // three clocks with no row sequencing
  sequence s_idle3;
    !pointerRun [*3];
  endsequence
  // row sequencing begins
  sequence s_start;
    $rose(pointerRun);
  endsequence
  ////////////////////////////////////////////////////////////
  chk_ptr_frozen: assert property (s_idle3 |-> $stable(rowReadPtr) && $stable(rowResetPtr))
    else $error("row pointers moved while halted");
  chk_start_dark: assert property (s_start |-> ##[1:2] rowKindOut == SFT_ROW_DARK)
    else $error("frame did not open with a dark row");
  chk_lv_in_fv: assert property (lineValidOut |-> frameValidOut)
    else $error("line valid outside frame valid");
  chk_fv_run: assert property (frameValidOut |-> pointerRun || $past(pointerRun))
    else $error("frame valid without row sequencing");
  chk_fv_active: assert property (frameValidOut && pointerRun |-> rowKindOut == SFT_ROW_ACTIVE)
    else $error("frame valid on a blanking row");
  chk_lv_fall: assert property ($fell(lineValidOut) |-> frameValidOut)
    else $error("line valid ended with the row");
  chk_sol_pulse: assert property (lineStartCode |=> !lineStartCode)
    else $error("line start code longer than one clock");
  chk_eof_eol: assert property (frameEndCode |-> lineEndCode)
    else $error("frame end code without line end code");
  chk_proto_excl: assert property (blankRowStartCode |-> !lineEndCode && !frameEndCode)
    else $error("blank row code mixed with end codes");
  chk_read_idle: assert property ((!$past(regRd) || $past(regAddr) > SFT_REG_FRM_CNT)
    |-> regRdata == 16'h0000)
    else $error("read data outside a read slot");
endmodule
bind sensor_frame_timing sft_monitor u_chk (.clk_sys, .rst, .regAddr, .regRd, .regRdata,
  .frameValidOut, .lineValidOut, .blankRowStartCode, .lineStartCode, .lineEndCode,
  .frameEndCode, .rowReadPtr, .rowResetPtr, .pointerRun, .rowKindOut);
`default_nettype wire

// ---- tb/testbench.sv ----
// testbench: reset values, free run layouts, standby and slave trigger
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sft_pkg::*;
  // design inputs
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        clkEn = 1'b1;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        frameSyncPulse;
  logic        prevRun = 1'b0;
  logic [15:0] prevPtr = 16'h0000;
  // design outputs
  logic [15:0] regRdata, rowReadPtr, rowResetPtr, v;
  logic        frameValidOut, lineValidOut, blankRowStartCode, frameStartCode;
  logic        lineStartCode, lineEndCode, frameEndCode, pointerRun;
  sft_row_t    rowKindOut;
  // bench state
  int tests_run = 0, mismatches = 0, cyc = 0, lastSof = 0, gap = 0, sofs = 0, want = 0;
  int fvCyc = 0, lvRun = 0, lvLen = 0, lineLen, act, t0, dummy;
  int cnt [8] = '{default: 0};
  int done [8];
  int dk [5] = '{8, 2, 2, 2, 4};
  int em [5] = '{1, 0, 1, 1, 1};
  int pr [5] = '{2, 1, 3, 0, 2};
  int rr [5];
  int ee [5];
  logic [15:0] rv [7] = '{SFT_RST_CTRL, SFT_RST_LINE_LEN, SFT_RST_FRM_LEN, SFT_RST_EXTRA,
                          SFT_RST_ACT_ROWS, SFT_RST_ACT_COLS, SFT_RST_INTEG};
  sensor_frame_timing uut (.clk_sys, .rst, .clkEn, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .frameSyncPulse, .frameValidOut, .lineValidOut, .blankRowStartCode,
    .frameStartCode, .lineStartCode, .lineEndCode, .frameEndCode, .rowReadPtr,
    .rowResetPtr, .pointerRun, .rowKindOut);
  sft_sync_source u_src (.clk_sys, .frameSyncPulse);
  ////////////////////////////////////////////////////////////
  // clock
  always #5 clk_sys = ~clk_sys;
  // marker monitor: a frame starts when the read pointer is back at row 0, in any protocol
  always @(posedge clk_sys) begin
    cyc++;
    if (frameValidOut === 1'b1) fvCyc++;
    if (pointerRun === 1'b1 && rowReadPtr === 16'h0000
        && !(prevRun === 1'b1 && prevPtr === 16'h0000)) begin
      gap = cyc - lastSof;
      lastSof = cyc;
      done = cnt;
      cnt = '{default: 0};
      fvCyc = 0;
      sofs++;
    end
    prevRun = pointerRun;
    prevPtr = rowReadPtr;
    if (blankRowStartCode === 1'b1 || lineStartCode === 1'b1) cnt[rowKindOut]++;
    if (frameStartCode === 1'b1) cnt[5]++;
    if (lineEndCode === 1'b1) cnt[6]++;
    if (frameEndCode === 1'b1) cnt[7]++;
    if (lineValidOut === 1'b1) lvRun++;
    else if (lvRun != 0) begin
      lvLen = lvRun;
      lvRun = 0;
    end
  end
  ////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // register write, strobe released with an edge between transfers
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    @(posedge clk_sys);
  endtask
  // register read, data taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    d = regRdata;
    @(posedge clk_sys);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    check(d, exp);
  endtask
  // wait for exactly one further frame start
  task automatic wait_sof(input int lim);
    want++;
    repeat (lim) if (sofs < want) @(posedge clk_sys);
    check(16'(sofs), 16'(want));
  endtask
  // control word: dark select, protocol, embedded enable, trigger/slave/stream
  function automatic logic [15:0] ctrl(input int i, input logic [2:0] low);
    return {4'h0, 4'(dk[i]), 2'b00, 2'(pr[i]), 1'(em[i]), low};
  endfunction
  // clocks of one frame from its layout
  function automatic int frame_clks(input int i);
    return (act + dk[i] + 8 + rr[i]) * lineLen + ee[i];
  endfunction
  // row kinds seen through row start codes
  task automatic chk_rows(input int i, input int a[8]);
    int s, p;
    s = (pr[i] == 1 || pr[i] == 2) ? 1 : 0;
    p = (pr[i] == 3) ? 1 : 0;
    check(16'(a[0]), 16'(s * dk[i]));
    check(16'(a[1]), 16'(s * 2 * em[i]));
    check(16'(a[2]), 16'(s * (4 - 2 * em[i])));
    check(16'(a[3]), 16'(s * (4 + rr[i])));
    check(16'(a[4]), 16'((pr[i] == 0) ? 0 : act));
    check(16'(a[5]), 16'(pr[i] >= 2));
    check(16'(a[6]), 16'(p * act));
    check(16'(a[7]), 16'(p));
  endtask
  // counts, verdict, end of run
  task automatic print_verdict();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    dummy = $urandom(32'heec80e96);
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 7; i++) rdchk(4'(i), rv[i]);
    clkEn <= 1'b0;
    wr(SFT_REG_LINE_LEN, 16'h0000);
    clkEn <= 1'b1;
    rdchk(SFT_REG_LINE_LEN, SFT_RST_LINE_LEN);
    wr(SFT_REG_STATUS, 16'hffff);
    rdchk(SFT_REG_STATUS, 16'h0000);
    rdchk(4'hb, 16'h0000);
    $display("test reset values done");
    lineLen = 1100 + $urandom % 16;
    act = 1 + $urandom % 2;
    for (int i = 0; i < 5; i++) begin
      rr[i] = (i == 4) ? 0 : $urandom % 3;
      ee[i] = $urandom % 8;
    end
    wr(SFT_REG_LINE_LEN, 16'(lineLen));
    wr(SFT_REG_ACT_ROWS, 16'(act));
    wr(SFT_REG_ACT_COLS, 16'h0010);
    // each frame's settings after the first written while the previous one runs
    for (int i = 0; i < 4; i++) begin
      wr(SFT_REG_FRM_LEN, (rr[i] == 0) ? 16'h0000 : 16'(act + dk[i] + 8 + rr[i]));
      wr(SFT_REG_EXTRA, 16'(ee[i]));
      wr(SFT_REG_CTRL, ctrl(i, 3'h1));
      wait_sof(30000);
      if (i > 0) begin
        chk_rows(i - 1, done);
        check(16'(gap), 16'(frame_clks(i - 1)));
      end
    end
    // stream cleared mid-frame: the parallel frame still completes
    wr(SFT_REG_CTRL, ctrl(3, 3'h0));
    rdchk(SFT_REG_STATUS, 16'h0002);
    repeat (30000) if (pointerRun) @(posedge clk_sys);
    repeat (20) @(posedge clk_sys);
    rdchk(SFT_REG_STATUS, 16'h0000);
    check(16'(fvCyc), 16'(act * lineLen));
    check(16'(lvLen), 16'h0010);
    check(16'(sofs), 16'(want));
    chk_rows(3, cnt);
    $display("test free run and standby done");
    // slave entry in order, then triggered frames
    wr(SFT_REG_CTRL, ctrl(4, 3'h2));
    wr(SFT_REG_CTRL, ctrl(4, 3'h6));
    wr(SFT_REG_FRM_LEN, 16'h0000);
    wr(SFT_REG_EXTRA, 16'(ee[4]));
    wr(SFT_REG_INTEG, 16'h0005);
    wr(SFT_REG_CTRL, ctrl(4, 3'h7));
    rdchk(SFT_REG_STATUS, 16'h0001);
    rd(SFT_REG_READ_PTR, v);
    check(v, 16'(act + dk[3] + 7 + rr[3]));
    repeat (20) @(posedge clk_sys);
    rdchk(SFT_REG_READ_PTR, v);
    u_src.send(3 + $urandom % 4);
    wait_sof(12);
    t0 = cyc;
    repeat (200) @(posedge clk_sys);
    u_src.send(3);
    while (cyc < t0 + frame_clks(4) + 5) @(posedge clk_sys);
    u_src.send(3);
    while (cyc < t0 + frame_clks(4) + 40) @(posedge clk_sys);
    rdchk(SFT_REG_STATUS, 16'h0001);
    check(16'(sofs), 16'(want));
    rdchk(SFT_REG_READ_PTR, 16'(act + dk[4] + 7));
    rdchk(SFT_REG_RST_PTR, 16'(act + dk[4] + 2));
    chk_rows(4, cnt);
    u_src.send(4);
    wait_sof(12);
    $display("test slave trigger done");
    print_verdict();
  end
  // watchdog against a hang
  initial begin
    repeat (98000) @(posedge clk_sys);
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
